// >>> hdl/dmrs_mode_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmrs_defines.svh"
module dmrs_mode_regs
    import dmrs_pkg::*;
#(
    // Vendor-programmed values (defaults arbitrary)
    parameter logic [7:0] CAPABILITY_VAL = 8'h44,
    parameter logic RFM_REQUIRED = 1'b1,
    parameter logic [4:0] INIT_THRESH_CODE = 5'h01,
    parameter logic [1:0] MAX_THRESH_CODE = 2'h0,
    parameter logic [7:0] REPAIR_AVAIL = 8'hff,
    parameter logic [1:0] SCALING_LEVEL = 2'h0,
    parameter logic [1:0] DECREMENT_MULT = 2'h0
)(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Mode register command port
    input wire logic mrw_valid,
    input wire logic mrr_valid,
    input wire logic [7:0] mr_addr,
    input wire logic [7:0] mr_wdata,
    output logic [7:0] mr_rdata,
    output logic mr_rvalid,
    // Read calibration command
    input wire logic cal_start,
    output logic [15:0] cal_data_lane,
    output logic [1:0] cal_mask_lane,
    output logic cal_busy,
    // Per-byte reference voltage settings
    output logic [6:0] lower_cmd_vref,
    output logic [6:0] upper_cmd_vref,
    output logic [6:0] lower_data_vref,
    output logic [6:0] upper_data_vref
);
    // ----------------------------------------
    // Writable state
    // ----------------------------------------
    logic [7:0] pat_a_q, pat_a_d;
    logic [7:0] pat_b_q, pat_b_d;
    logic [1:0] sel_q, sel_d;
    logic [7:0] linv_q, linv_d;
    logic [7:0] uinv_q, uinv_d;
    logic [6:0] lcv_q, lcv_d, ucv_q, ucv_d, ldv_q, ldv_d, udv_q, udv_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic lower_ok, upper_ok;

    // Byte targeting from selection field: bit 6 blocks lower, bit 7 upper
    assign lower_ok = ~sel_q[0];
    assign upper_ok = ~sel_q[1];

    // Write decode; read-only and test addresses have no write path
    always_comb begin
        pat_a_d = pat_a_q;
        pat_b_d = pat_b_q;
        sel_d = sel_q;
        linv_d = linv_q;
        uinv_d = uinv_q;
        lcv_d = lcv_q;
        ucv_d = ucv_q;
        ldv_d = ldv_q;
        udv_d = udv_q;
        if (mrw_valid) begin
            unique case (mr_addr)
                `DMRS_ADDR_PATTERN_A: pat_a_d = mr_wdata;
                `DMRS_ADDR_PATTERN_B: pat_b_d = mr_wdata;
                `DMRS_ADDR_BYTE_VREF_SEL: begin
                    sel_d = {mr_wdata[`DMRS_SEL_UPPER_BIT], mr_wdata[`DMRS_SEL_LOWER_BIT]};
                end
                `DMRS_ADDR_LOWER_INV: linv_d = mr_wdata;
                `DMRS_ADDR_UPPER_INV: uinv_d = mr_wdata;
                `DMRS_ADDR_CMD_VREF: begin
                    if (lower_ok) begin
                        lcv_d = mr_wdata[`DMRS_VREF_MSB:0];
                    end
                    if (upper_ok) begin
                        ucv_d = mr_wdata[`DMRS_VREF_MSB:0];
                    end
                end
                `DMRS_ADDR_DATA_VREF: begin
                    if (lower_ok) begin
                        ldv_d = mr_wdata[`DMRS_VREF_MSB:0];
                    end
                    if (upper_ok) begin
                        udv_d = mr_wdata[`DMRS_VREF_MSB:0];
                    end
                end
                // Test register and read-only fields are dropped here
                default: begin
                end
            endcase
        end
    end

    // Read mux; write-only registers read as zero
    always_comb begin
        rvalid_d = mrr_valid;
        rdata_d = rdata_q;
        if (mrr_valid) begin
            unique case (mr_addr)
                `DMRS_ADDR_CAPABILITY: rdata_d = CAPABILITY_VAL;
                `DMRS_ADDR_RFM_THRESH: rdata_d = {MAX_THRESH_CODE, INIT_THRESH_CODE, RFM_REQUIRED};
                `DMRS_ADDR_REPAIR: rdata_d = REPAIR_AVAIL;
                `DMRS_ADDR_SCALING: rdata_d = {6'h00, SCALING_LEVEL};
                `DMRS_ADDR_DECREMENT: rdata_d = {6'h00, DECREMENT_MULT};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pat_a_q <= `DMRS_RST_PATTERN_A;
            pat_b_q <= `DMRS_RST_PATTERN_B;
            sel_q <= `DMRS_RST_SEL;
            linv_q <= `DMRS_RST_INV;
            uinv_q <= `DMRS_RST_INV;
            lcv_q <= `DMRS_RST_VREF;
            ucv_q <= `DMRS_RST_VREF;
            ldv_q <= `DMRS_RST_VREF;
            udv_q <= `DMRS_RST_VREF;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            pat_a_q <= pat_a_d;
            pat_b_q <= pat_b_d;
            sel_q <= sel_d;
            linv_q <= linv_d;
            uinv_q <= uinv_d;
            lcv_q <= lcv_d;
            ucv_q <= ucv_d;
            ldv_q <= ldv_d;
            udv_q <= udv_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign mr_rdata = rdata_q;
    assign mr_rvalid = rvalid_q;
    assign lower_cmd_vref = lcv_q;
    assign upper_cmd_vref = ucv_q;
    assign lower_data_vref = ldv_q;
    assign upper_data_vref = udv_q;

    // ----------------------------------------
    // Calibration serializer
    // ----------------------------------------
    // Start is ignored while a burst is in flight
    dmrs_cal_serializer u_cal (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(cal_start),
        .pattern_a(pat_a_q),
        .pattern_b(pat_b_q),
        .lane_invert({uinv_q, linv_q}),
        .data_lane(cal_data_lane),
        .mask_lane(cal_mask_lane),
        .busy(cal_busy)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_repair_read;
        @(posedge clk) disable iff (sys_rst)
        (mrr_valid && mr_addr == `DMRS_ADDR_REPAIR) |=> (mr_rvalid && mr_rdata == REPAIR_AVAIL);
    endproperty
    a_repair_read: assert property (p_repair_read) else $error("repair read wrong");

    property p_scaling_read;
        @(posedge clk) disable iff (sys_rst)
        (mrr_valid && mr_addr == `DMRS_ADDR_SCALING) |=> (mr_rdata == {6'h00, SCALING_LEVEL});
    endproperty
    a_scaling_read: assert property (p_scaling_read) else $error("scaling read wrong");

    property p_test_noeffect;
        @(posedge clk) disable iff (sys_rst)
        (mrw_valid && mr_addr == `DMRS_ADDR_TEST_RSVD) |=>
            ($stable(pat_a_q) && $stable(sel_q) && $stable(lcv_q) && $stable(udv_q));
    endproperty
    a_test_noeffect: assert property (p_test_noeffect) else $error("test write had effect");

    property p_sel01;
        @(posedge clk) disable iff (sys_rst)
        (mrw_valid && mr_addr == `DMRS_ADDR_CMD_VREF && sel_q == 2'h1) |=>
            ($stable(lcv_q) && ucv_q == $past(mr_wdata[6:0]));
    endproperty
    a_sel01: assert property (p_sel01) else $error("select 01 misbehaved");

    property p_sel10;
        @(posedge clk) disable iff (sys_rst)
        (mrw_valid && mr_addr == `DMRS_ADDR_DATA_VREF && sel_q == 2'h2) |=>
            ($stable(udv_q) && ldv_q == $past(mr_wdata[6:0]));
    endproperty
    a_sel10: assert property (p_sel10) else $error("select 10 misbehaved");

    property p_sel00;
        @(posedge clk) disable iff (sys_rst)
        (mrw_valid && mr_addr == `DMRS_ADDR_DATA_VREF && sel_q == 2'h0) |=>
            (ldv_q == udv_q);
    endproperty
    a_sel00: assert property (p_sel00) else $error("select 00 not both");

    property p_blocked_stable;
        @(posedge clk) disable iff (sys_rst)
        (sel_q == 2'h3) |=> ($stable(lcv_q) && $stable(ucv_q) && $stable(ldv_q) && $stable(udv_q));
    endproperty
    a_blocked_stable: assert property (p_blocked_stable) else $error("blocked byte updated");

    property p_pat_a_write;
        @(posedge clk) disable iff (sys_rst)
        (mrw_valid && mr_addr == `DMRS_ADDR_PATTERN_A) |=> (pat_a_q == $past(mr_wdata));
    endproperty
    a_pat_a_write: assert property (p_pat_a_write) else $error("pattern A not loaded");

    property p_cal_first_bit;
        @(posedge clk) disable iff (sys_rst)
        (cal_start && !cal_busy && linv_q == 8'h00) |=> ##1 (cal_mask_lane[0] == $past(pat_a_q[0], 2));
    endproperty
    a_cal_first_bit: assert property (p_cal_first_bit) else $error("first bit not A lsb");

    property p_cal_length;
        @(posedge clk) disable iff (sys_rst)
        (cal_start && !cal_busy) |=> cal_busy [*8] ##1 cal_busy [*8] ##1 !cal_busy;
    endproperty
    a_cal_length: assert property (p_cal_length) else $error("burst length wrong");

    property p_mask_uninverted;
        @(posedge clk) disable iff (sys_rst)
        (cal_busy && linv_q[0]) |=> (cal_data_lane[0] != cal_mask_lane[0]);
    endproperty
    a_mask_uninverted: assert property (p_mask_uninverted) else $error("mask lane inverted");

    property p_decrement_read;
        @(posedge clk) disable iff (sys_rst)
        (mrr_valid && mr_addr == `DMRS_ADDR_DECREMENT) |=> (mr_rdata[7:2] == 6'h00 && mr_rdata[1:0] == DECREMENT_MULT);
    endproperty
    a_decrement_read: assert property (p_decrement_read) else $error("multiplier read wrong");

    property p_thresh_read;
        @(posedge clk) disable iff (sys_rst)
        (mrr_valid && mr_addr == `DMRS_ADDR_RFM_THRESH) |=>
            (mr_rdata == {MAX_THRESH_CODE, INIT_THRESH_CODE, RFM_REQUIRED});
    endproperty
    a_thresh_read: assert property (p_thresh_read) else $error("threshold read wrong");

    // Writes aimed at vendor fields must leave every writable field alone
    property p_ro_write_ignored;
        @(posedge clk) disable iff (sys_rst)
        (mrw_valid && mr_addr inside {`DMRS_ADDR_CAPABILITY, `DMRS_ADDR_RFM_THRESH, `DMRS_ADDR_REPAIR,
            `DMRS_ADDR_SCALING, `DMRS_ADDR_DECREMENT}) |=>
            ($stable(pat_a_q) && $stable(pat_b_q) && $stable(sel_q) && $stable(linv_q) && $stable(uinv_q)
            && $stable(lcv_q) && $stable(ucv_q) && $stable(ldv_q) && $stable(udv_q));
    endproperty
    a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("read-only write had effect");

    // One answer per read strobe, standing for exactly one cycle
    property p_rvalid_pulse;
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> (mr_rvalid == $past(mrr_valid));
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer strobe wrong");

    property p_cal_last_bit;
        @(posedge clk) disable iff (sys_rst)
        (cal_start && !cal_busy) |=> ##16 (cal_mask_lane[0] == $past(pat_b_q[7], 17));
    endproperty
    a_cal_last_bit: assert property (p_cal_last_bit) else $error("last bit not B msb");

    // Lanes rest at zero so a stray bit outside a burst is visible
    property p_idle_lanes;
        @(posedge clk) disable iff (sys_rst)
        !cal_busy |=> (cal_data_lane == 16'h0000 && cal_mask_lane == 2'h0);
    endproperty
    a_idle_lanes: assert property (p_idle_lanes) else $error("lanes active outside burst");

    c_cal: cover property (@(posedge clk) disable iff (sys_rst) cal_start && !cal_busy);
    c_sel01: cover property (@(posedge clk) disable iff (sys_rst) sel_q == 2'h1 && mrw_valid);
    c_thresh: cover property (@(posedge clk) disable iff (sys_rst) mrr_valid && mr_addr == `DMRS_ADDR_RFM_THRESH);
    c_blocked: cover property (@(posedge clk) disable iff (sys_rst) sel_q == 2'h3 && mrw_valid);
endmodule : dmrs_mode_regs
`default_nettype wire

// >>> hdl/dmrs_defines.svh
`ifndef DMRS_DEFINES_SVH
`define DMRS_DEFINES_SVH
// ----------------------------------------
// Mode register addresses
// ----------------------------------------
`define DMRS_ADDR_CAPABILITY 8'h00
`define DMRS_ADDR_CMD_VREF 8'h0c
`define DMRS_ADDR_DATA_VREF 8'h0e
`define DMRS_ADDR_LOWER_INV 8'h0f
`define DMRS_ADDR_UPPER_INV 8'h14
`define DMRS_ADDR_RFM_THRESH 8'h18
`define DMRS_ADDR_REPAIR 8'h19
`define DMRS_ADDR_SCALING 8'h1a
`define DMRS_ADDR_DECREMENT 8'h1b
`define DMRS_ADDR_TEST_RSVD 8'h1e
`define DMRS_ADDR_BYTE_VREF_SEL 8'h1f
`define DMRS_ADDR_PATTERN_A 8'h20
`define DMRS_ADDR_PATTERN_B 8'h28
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DMRS_CAP_SCALING_BIT 6
`define DMRS_CAP_RFM_BIT 2
`define DMRS_SEL_LOWER_BIT 6
`define DMRS_SEL_UPPER_BIT 7
`define DMRS_VREF_MSB 6
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DMRS_RST_PATTERN_A 8'h5a
`define DMRS_RST_PATTERN_B 8'h3c
`define DMRS_RST_SEL 2'h0
`define DMRS_RST_VREF 7'h4d
`define DMRS_RST_INV 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define DMRS_CAL_BITS 16
`endif

// >>> hdl/dmrs_pkg.sv
`default_nettype none
package dmrs_pkg;
    // Calibration serializer states
    typedef enum logic [1:0] {
        DMRS_CAL_IDLE = 2'b00,
        DMRS_CAL_SEND = 2'b01
    } dmrs_cal_state_t;
endpackage : dmrs_pkg
`default_nettype wire

// >>> hdl/dmrs_cal_serializer.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmrs_defines.svh"
module dmrs_cal_serializer
    import dmrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic start,
    input wire logic [7:0] pattern_a,
    input wire logic [7:0] pattern_b,
    input wire logic [15:0] lane_invert,
    // Lane outputs
    output logic [15:0] data_lane,
    output logic [1:0] mask_lane,
    output logic busy
);
    // ----------------------------------------
    // Bit counter and shift state
    // ----------------------------------------
    dmrs_cal_state_t state_q, state_d;
    logic [15:0] shift_q, shift_d;
    logic [4:0] cnt_q, cnt_d;
    logic [15:0] data_q, data_d;
    logic [1:0] mask_q, mask_d;

    // Pattern A then B, each LSB first, one bit per cycle
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        data_d = '0;
        mask_d = '0;
        unique case (state_q)
            DMRS_CAL_IDLE: begin
                if (start) begin
                    shift_d = {pattern_b, pattern_a};
                    cnt_d = 5'h00;
                    state_d = DMRS_CAL_SEND;
                end
            end
            DMRS_CAL_SEND: begin
                // No bus inversion here; only per-lane invert applies
                data_d = {16{shift_q[0]}} ^ lane_invert;
                mask_d = {2{shift_q[0]}};
                shift_d = {1'b0, shift_q[15:1]};
                cnt_d = cnt_q + 5'h01;
                if (cnt_q == 5'(`DMRS_CAL_BITS - 1)) begin
                    state_d = DMRS_CAL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= DMRS_CAL_IDLE;
            shift_q <= 16'h0000;
            cnt_q <= 5'h00;
            data_q <= 16'h0000;
            mask_q <= 2'h0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            data_q <= data_d;
            mask_q <= mask_d;
        end
    end

    assign data_lane = data_q;
    assign mask_lane = mask_q;
    assign busy = (state_q == DMRS_CAL_SEND);
endmodule : dmrs_cal_serializer
`default_nettype wire

// >>> tb/dmrs_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmrs_defines.svh"
// ----------------------------------------
// Controller model for the mode register port
// ----------------------------------------
module dmrs_ctrl_model #(
    parameter bit BYTE_MODE = 1'b1
)(
    // Clock
    input wire logic clk,
    // Command outputs
    output logic mrw_valid,
    output logic mrr_valid,
    output logic [7:0] mr_addr,
    output logic [7:0] mr_wdata,
    // Read answer
    input wire logic [7:0] mr_rdata,
    input wire logic mr_rvalid
);
    // Idle port at time zero
    initial begin
        mrw_valid = 1'b0;
        mrr_valid = 1'b0;
        mr_addr = 8'h00;
        mr_wdata = 8'h00;
    end

    // Same spacing for every register, the ignored test one too
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        if (!BYTE_MODE && addr == `DMRS_ADDR_BYTE_VREF_SEL) begin
            data = 8'h00;
        end
        @(posedge clk);
        mrw_valid <= 1'b1;
        mr_addr <= addr;
        mr_wdata <= data;
        @(posedge clk);
        mrw_valid <= 1'b0;
        // Released lines must not look like a held value
        mr_addr <= ~addr;
        mr_wdata <= ~data;
    endtask : write_reg

    // Answer is taken one cycle after the strobe
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(posedge clk);
        mrr_valid <= 1'b1;
        mr_addr <= addr;
        @(posedge clk);
        mrr_valid <= 1'b0;
        mr_addr <= ~addr;
        #1;
        ok = mr_rvalid;
        data = mr_rdata;
    endtask : read_reg
endmodule : dmrs_ctrl_model
`default_nettype wire

// >>> tb/dram_mode_register_subset_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "dmrs_defines.svh"
module dram_mode_register_subset_tb_top;
    // ----------------------------------------
    // Signals and vendor values
    // ----------------------------------------
    localparam logic [7:0] CAP = 8'h44;
    localparam logic [7:0] REP = 8'ha5;
    localparam logic [1:0] SCL = 2'h2;
    localparam logic [1:0] DEC = 2'h1;
    localparam logic [4:0] INIT = 5'h1f;
    localparam logic [1:0] MAXT = 2'h3;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cal_start = 1'b0;
    logic mrw_valid, mrr_valid, mr_rvalid, cal_busy;
    logic [7:0] mr_addr, mr_wdata, mr_rdata;
    logic [15:0] cal_data_lane;
    logic [1:0] cal_mask_lane;
    logic [6:0] lc, uc, ld, ud;
    logic [6:0] e_lc = 7'h4d, e_uc = 7'h4d, e_ld = 7'h4d, e_ud = 7'h4d;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    // Clock at 50 MHz
    always #10 clk = ~clk;

    dmrs_mode_regs #(.CAPABILITY_VAL(CAP), .RFM_REQUIRED(1'b1), .INIT_THRESH_CODE(INIT),
        .MAX_THRESH_CODE(MAXT), .REPAIR_AVAIL(REP), .SCALING_LEVEL(SCL), .DECREMENT_MULT(DEC)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .mrw_valid(mrw_valid), .mrr_valid(mrr_valid),
        .mr_addr(mr_addr), .mr_wdata(mr_wdata), .mr_rdata(mr_rdata), .mr_rvalid(mr_rvalid),
        .cal_start(cal_start), .cal_data_lane(cal_data_lane), .cal_mask_lane(cal_mask_lane),
        .cal_busy(cal_busy), .lower_cmd_vref(lc), .upper_cmd_vref(uc),
        .lower_data_vref(ld), .upper_data_vref(ud));

    dmrs_ctrl_model #(.BYTE_MODE(1'b1)) i_ctrl (
        .clk(clk), .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr),
        .mr_wdata(mr_wdata), .mr_rdata(mr_rdata), .mr_rvalid(mr_rvalid));

    // ----------------------------------------
    // Compare tasks and closing report
    // ----------------------------------------
    task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_reg

    task automatic chk_vref();
        cmp_count++;
        if ({lc, uc, ld, ud} !== {e_lc, e_uc, e_ld, e_ud}) begin
            fail_count++;
            $display("wrong value vref expected %h seen %h", {e_lc, e_uc, e_ld, e_ud}, {lc, uc, ld, ud});
        end
    endtask : chk_vref

    task automatic chk_lane(input string what, input logic [17:0] exp);
        cmp_count++;
        if ({cal_busy, cal_mask_lane, cal_data_lane} !== {what == "busy", exp}) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, {what == "busy", exp},
                {cal_busy, cal_mask_lane, cal_data_lane});
        end
    endtask : chk_lane

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // Read through the controller and check both the strobe and the data
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_ctrl.read_reg(addr, d, ok);
        chk_reg("read strobe", 8'h01, {7'h00, ok});
        chk_reg("read data", exp, d);
    endtask : rd

    // Run one calibration burst; a second start lands mid-burst and must be ignored
    task automatic run_cal(input logic [7:0] a, input logic [7:0] b, input logic [15:0] inv);
        logic [15:0] pat;
        pat = {b, a};
        @(posedge clk);
        cal_start <= 1'b1;
        @(posedge clk);
        cal_start <= 1'b0;
        #1;
        chk_lane("busy", 18'h0);
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            cal_start <= (k == 3);
            #1;
            // Lanes carry one pattern bit, lsb first; mask lanes never inverted
            chk_lane(k < 15 ? "busy" : "lane", {{2{pat[k]}}, {16{pat[k]}} ^ inv});
        end
        @(posedge clk);
        #1;
        chk_lane("idle", 18'h0);
    endtask : run_cal

    // ----------------------------------------
    // Hang guard, far above the roughly 150 cycles the tests need
    // ----------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 3000) begin
            fail_count++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        static logic [7:0] addrs [5] = '{`DMRS_ADDR_CAPABILITY, `DMRS_ADDR_RFM_THRESH, `DMRS_ADDR_REPAIR,
            `DMRS_ADDR_SCALING, `DMRS_ADDR_DECREMENT};
        static logic [7:0] vals [5] = '{CAP, {MAXT, INIT, 1'b1}, REP, {6'h00, SCL}, {6'h00, DEC}};
        logic [1:0] sel;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        chk_vref();
        run_cal(`DMRS_RST_PATTERN_A, `DMRS_RST_PATTERN_B, 16'h0000);
        $display("test calibration defaults done");
        // Read-only values survive writes of their complement
        for (int i = 0; i < 5; i++) begin
            rd(addrs[i], vals[i]);
            i_ctrl.write_reg(addrs[i], ~vals[i]);
            rd(addrs[i], vals[i]);
        end
        rd(8'h3f, 8'h00);
        $display("test read-only registers done");
        // Test register takes anything and changes nothing
        i_ctrl.write_reg(`DMRS_ADDR_TEST_RSVD, 8'hff);
        i_ctrl.write_reg(`DMRS_ADDR_TEST_RSVD, 8'h00);
        chk_vref();
        rd(`DMRS_ADDR_RFM_THRESH, vals[1]);
        $display("test ignored register done");
        // Every select code, then a write to both reference registers
        for (int j = 0; j < 4; j++) begin
            sel = j[1:0];
            i_ctrl.write_reg(`DMRS_ADDR_BYTE_VREF_SEL, {sel, 6'h00});
            i_ctrl.write_reg(`DMRS_ADDR_CMD_VREF, 8'h90 + 8'(j));
            i_ctrl.write_reg(`DMRS_ADDR_DATA_VREF, 8'ha0 + 8'(j));
            if (!sel[0]) begin
                e_lc = 7'h10 + 7'(j);
                e_ld = 7'h20 + 7'(j);
            end
            if (!sel[1]) begin
                e_uc = 7'h10 + 7'(j);
                e_ud = 7'h20 + 7'(j);
            end
            @(posedge clk);
            #1;
            chk_vref();
        end
        i_ctrl.write_reg(`DMRS_ADDR_BYTE_VREF_SEL, 8'h00);
        $display("test byte reference select done");
        // New pattern and per-lane inversion
        i_ctrl.write_reg(`DMRS_ADDR_PATTERN_A, 8'h27);
        i_ctrl.write_reg(`DMRS_ADDR_PATTERN_B, 8'hc3);
        i_ctrl.write_reg(`DMRS_ADDR_LOWER_INV, 8'h81);
        i_ctrl.write_reg(`DMRS_ADDR_UPPER_INV, 8'h40);
        rd(`DMRS_ADDR_PATTERN_A, 8'h00);
        run_cal(8'h27, 8'hc3, 16'h4081);
        $display("test calibration inverted done");
        // Reset between bursts, with the serializer idle, must reload both patterns and clear the inverts
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        run_cal(`DMRS_RST_PATTERN_A, `DMRS_RST_PATTERN_B, 16'h0000);
        $display("test reset reload done");
        end_sim();
    end
endmodule : dram_mode_register_subset_tb_top
`default_nettype wire
